// file: lsd_core.sv
// Summary of operation
// - Instructions are fixed 16-bit words.
// - Register moves complete one per clock.
// - Extension prefixes widen immediates to 24 bits.
// - Eight 24-bit general registers.
// - Special registers: PC, SP 24-bit, PSR 8-bit.
// - All addresses are 24 bits.
// - Separate 16-bit fetch and 32-bit data buses.
// - Reset, NMI, 32 lines, misalign, debug.
// - Interrupt fetches vector entry, branches directly.
// - Software interrupt selects any vector number.
// - Coprocessor multiply, divide, multiply-accumulate.
// - Signed byte loads sign-extend from bit 7.
// - Unsigned byte loads zero-fill upper bits.
// - Byte stores write only low byte.
// - Indirect plain, post-inc, post-dec, pre-dec forms.
// - Halfword loads/stores move 16 bits; odd addresses trap.
// - Signed 7-bit immediate load sign-extends.
// - 24-bit move copies all; short_unsigned_immediate zero-extends.
// - Stack forms address SP plus unsigned short_unsigned_immediate.
`timescale 1ns/100ps
module lsd_core #(
  parameter int NUM_IRQ = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Instruction fetch bus.
  output logic [23:0] iAddr,
  input wire logic [15:0] iData,
  input wire logic iValid,
  // Data bus.
  output logic [23:0] dAddr,
  output logic [3:0] dBe,
  output logic [31:0] dWdata,
  output logic dRead,
  output logic dWrite,
  input wire logic [31:0] dRdata,
  input wire logic dAck,
  // Interrupt sources.
  input wire logic nmiReq,
  input wire logic dbgReq,
  input wire logic [NUM_IRQ-1:0] irq,
  // Coprocessor port.
  output logic copStart,
  output logic [1:0] copOp,
  output logic [15:0] copA,
  output logic [15:0] copB,
  input wire logic [31:0] copResult,
  input wire logic copDone
);
  lsd_pkg::lsd_core_s_t s;
  lsd_pkg::lsd_core_s_t next_s;

  // Fixed-width instruction fields.
  logic [3:0] opc;
  logic [1:0] fSize;
  logic [2:0] fRd;
  logic [2:0] fRs;
  logic [1:0] fMode;
  logic [6:0] fImm7;
  logic [23:0] srcVal;
  logic intReq;
  logic runOk;
  assign opc = iData[15:12];
  assign fSize = iData[11:10];
  assign fRd = iData[9:7];
  assign fRs = iData[6:4];
  assign fMode = iData[3:2];
  assign fImm7 = iData[6:0];
  assign srcVal = s.gpr[fRs];
  // A pending prefix binds to the next word, so interrupts wait for it.
  assign intReq = !s.extValid && (s.nmiPend || dbgReq ||
                  ((|irq) && s.psr[lsd_pkg::PSR_IE]));
  assign runOk = s.state == lsd_pkg::LSD_RUN && iValid && !intReq;

  always_comb begin
    logic [23:0] immZ;
    logic [23:0] immS;
    logic [23:0] addr;
    logic [23:0] step;
    logic [23:0] src;
    logic [5:0] vecNum;
    logic [5:0] irqNum;
    logic vecGo;
    logic isStore;
    logic [7:0] bval;
    logic [15:0] hval;
    immZ = s.extValid ? {s.ext[16:0], fImm7} : {17'h00000, fImm7};
    immS = s.extValid ? {s.ext[16:0], fImm7} : {{17{fImm7[6]}}, fImm7};
    addr = s.gpr[fRs];
    step = (fSize == lsd_pkg::SZ_HALF) ? lsd_pkg::STEP_HALF : lsd_pkg::STEP_BYTE;
    src = s.gpr[fRd];
    vecNum = lsd_pkg::VEC_RESET;
    irqNum = lsd_pkg::VEC_EXT0;
    vecGo = 1'b0;
    isStore = opc[0];
    bval = dRdata[{s.dAddr[1:0], 3'b000} +: 8];
    hval = dRdata[{s.dAddr[1], 4'h0} +: 16];
    next_s = s;
    next_s.copStart = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq[i]) begin
        irqNum = lsd_pkg::VEC_EXT0 + 6'(i);
      end
    end
    unique case (s.state)
      lsd_pkg::LSD_RUN: begin
        if (intReq) begin
          vecGo = 1'b1;
          if (s.nmiPend) begin
            vecNum = lsd_pkg::VEC_NMI;
            next_s.nmiPend = 1'b0;
          end else if (dbgReq) begin
            vecNum = lsd_pkg::VEC_DEBUG;
          end else begin
            vecNum = irqNum;
          end
        end else if (iValid) begin
          next_s.iAddr = s.iAddr + lsd_pkg::INSTR_BYTES;
          next_s.extValid = 1'b0;
          unique case (opc)
            lsd_pkg::OP_EXT: begin
              next_s.ext = s.extValid ? {s.ext[11:0], iData[11:0]} : {12'h000, iData[11:0]};
              next_s.extValid = 1'b1;
            end
            lsd_pkg::OP_MOVR: begin
              unique case (fSize)
                lsd_pkg::SZ_SBYTE: next_s.gpr[fRd] = {{16{srcVal[7]}}, srcVal[7:0]};
                lsd_pkg::SZ_UBYTE: next_s.gpr[fRd] = {16'h0000, srcVal[7:0]};
                lsd_pkg::SZ_HALF: next_s.gpr[fRd] = {8'h00, srcVal[15:0]};
                lsd_pkg::SZ_WORD24: next_s.gpr[fRd] = srcVal;
              endcase
            end
            lsd_pkg::OP_MOVI: begin
              unique case (fSize)
                lsd_pkg::MI_SHORT_SIGNED_IMMEDIATE: next_s.gpr[fRd] = immS;
                lsd_pkg::MI_ZERO7: next_s.gpr[fRd] = immZ;
                lsd_pkg::MI_SETSP: next_s.sp = s.gpr[fRd];
                lsd_pkg::MI_GETSP: next_s.gpr[fRd] = s.sp;
              endcase
            end
            lsd_pkg::OP_LDRB, lsd_pkg::OP_STRB, lsd_pkg::OP_LDSP,
            lsd_pkg::OP_STSP, lsd_pkg::OP_LDAB, lsd_pkg::OP_STAB: begin
              if (opc == lsd_pkg::OP_LDSP || opc == lsd_pkg::OP_STSP) begin
                addr = s.sp + immZ;
              end else if (opc == lsd_pkg::OP_LDAB || opc == lsd_pkg::OP_STAB) begin
                addr = immZ;
              end else if (fMode == lsd_pkg::AM_PREDEC) begin
                addr = s.gpr[fRs] - step;
              end
              if (fSize == lsd_pkg::SZ_WORD24) begin
                next_s.iAddr = s.iAddr + lsd_pkg::INSTR_BYTES;
              end else if (fSize == lsd_pkg::SZ_HALF && addr[0]) begin
                vecGo = 1'b1;
                vecNum = lsd_pkg::VEC_MISALIGN;
              end else begin
                if (opc == lsd_pkg::OP_LDRB || opc == lsd_pkg::OP_STRB) begin
                  unique case (fMode)
                    lsd_pkg::AM_PLAIN: next_s.gpr[fRs] = s.gpr[fRs];
                    lsd_pkg::AM_POSTINC: next_s.gpr[fRs] = s.gpr[fRs] + step;
                    lsd_pkg::AM_POSTDEC, lsd_pkg::AM_PREDEC: next_s.gpr[fRs] = s.gpr[fRs] - step;
                  endcase
                end
                next_s.dAddr = addr;
                next_s.destReg = fRd;
                next_s.memSize = fSize;
                next_s.dRead = !isStore;
                next_s.dWrite = isStore;
                if (fSize == lsd_pkg::SZ_HALF) begin
                  next_s.dBe = addr[1] ? 4'hC : 4'h3;
                  next_s.dWdata = {2{src[15:0]}};
                end else begin
                  next_s.dBe = 4'h1 << addr[1:0];
                  next_s.dWdata = {4{src[7:0]}};
                end
                next_s.state = lsd_pkg::LSD_MEM;
              end
            end
            lsd_pkg::OP_SWI: begin
              vecGo = 1'b1;
              vecNum = iData[5:0];
            end
            lsd_pkg::OP_COP: begin
              next_s.copStart = 1'b1;
              next_s.copOp = fSize;
              next_s.copA = s.gpr[fRd][15:0];
              next_s.copB = srcVal[15:0];
              next_s.destReg = fRd;
              next_s.state = lsd_pkg::LSD_COP;
            end
            lsd_pkg::OP_IEN: next_s.psr[lsd_pkg::PSR_IE] = iData[0];
            default: next_s.iAddr = s.iAddr + lsd_pkg::INSTR_BYTES;
          endcase
        end
      end
      lsd_pkg::LSD_MEM: begin
        if (dAck) begin
          next_s.dRead = 1'b0;
          next_s.dWrite = 1'b0;
          next_s.state = lsd_pkg::LSD_RUN;
          if (s.dRead) begin
            unique case (s.memSize)
              lsd_pkg::SZ_SBYTE: next_s.gpr[s.destReg] = {{16{bval[7]}}, bval};
              lsd_pkg::SZ_UBYTE: next_s.gpr[s.destReg] = {16'h0000, bval};
              lsd_pkg::SZ_HALF: next_s.gpr[s.destReg] = {8'h00, hval};
              lsd_pkg::SZ_WORD24: next_s.gpr[s.destReg] = s.gpr[s.destReg];
            endcase
          end
        end
      end
      lsd_pkg::LSD_VEC: begin
        if (dAck) begin
          next_s.dRead = 1'b0;
          next_s.iAddr = dRdata[23:0];
          next_s.state = lsd_pkg::LSD_RUN;
        end
      end
      lsd_pkg::LSD_COP: begin
        if (copDone) begin
          next_s.gpr[s.destReg] = copResult[23:0];
          next_s.state = lsd_pkg::LSD_RUN;
        end
      end
    endcase
    if (vecGo) begin
      next_s.iAddr = s.iAddr;
      next_s.dAddr = lsd_pkg::TABLE_BASE + {16'h0000, vecNum, 2'b00};
      next_s.dBe = lsd_pkg::BE_ALL;
      next_s.dRead = 1'b1;
      next_s.psr[lsd_pkg::PSR_IE] = 1'b0;
      next_s.state = lsd_pkg::LSD_VEC;
    end
    // A new NMI in the cycle it is consumed stays pending.
    if (nmiReq) begin
      next_s.nmiPend = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.state <= lsd_pkg::LSD_VEC;
      s.dAddr <= lsd_pkg::TABLE_BASE;
      s.dBe <= lsd_pkg::BE_ALL;
      s.dRead <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign iAddr = s.iAddr;
  assign dAddr = s.dAddr;
  assign dBe = s.dBe;
  assign dWdata = s.dWdata;
  assign dRead = s.dRead;
  assign dWrite = s.dWrite;
  assign copStart = s.copStart;
  assign copOp = s.copOp;
  assign copA = s.copA;
  assign copB = s.copB;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_fetch_step: assert property (runOk && opc == lsd_pkg::OP_NOP |=>
    iAddr == $past(iAddr) + lsd_pkg::INSTR_BYTES) else $error("fetch step not 2");
  chk_move_rate: assert property (runOk && opc == lsd_pkg::OP_MOVR ##1
    runOk && opc == lsd_pkg::OP_MOVR |=> s.state == lsd_pkg::LSD_RUN &&
    iAddr == $past(iAddr, 2) + 24'h000004) else $error("moves not one per cycle");
  chk_byte_sext: assert property (runOk && opc == lsd_pkg::OP_MOVR && fSize ==
    lsd_pkg::SZ_SBYTE |=> s.gpr[$past(fRd)][23:8] == {16{$past(srcVal[7])}})
    else $error("signed byte not extended");
  chk_byte_zext: assert property (s.state == lsd_pkg::LSD_MEM && dAck && dRead &&
    s.memSize == lsd_pkg::SZ_UBYTE |=> s.gpr[$past(s.destReg)][23:8] == 16'h0000)
    else $error("unsigned byte not zero-filled");
  chk_byte_lane: assert property (runOk && opc == lsd_pkg::OP_STRB && !fSize[1] |=>
    dWrite && $onehot(dBe)) else $error("byte store lanes wrong");
  chk_post_inc: assert property (runOk && (opc == lsd_pkg::OP_LDRB ||
    opc == lsd_pkg::OP_STRB) && fSize == lsd_pkg::SZ_HALF &&
    fMode == lsd_pkg::AM_POSTINC && !srcVal[0] && fRd != fRs |=>
    s.gpr[$past(fRs)] == $past(srcVal) + lsd_pkg::STEP_HALF && dAddr == $past(srcVal))
    else $error("post increment wrong");
  chk_sign_imm: assert property (runOk && !s.extValid && opc == lsd_pkg::OP_MOVI &&
    fSize == lsd_pkg::MI_SHORT_SIGNED_IMMEDIATE |=> s.gpr[$past(fRd)][23:7] == {17{$past(fImm7[6])}})
    else $error("short_signed_immediate not extended");
  chk_zero_imm: assert property (runOk && !s.extValid && opc == lsd_pkg::OP_MOVI &&
    fSize == lsd_pkg::MI_ZERO7 |=> s.gpr[$past(fRd)] == {17'h00000, $past(fImm7)})
    else $error("short_unsigned_immediate not zero-extended");
  chk_sp_addr: assert property (runOk && !s.extValid && opc == lsd_pkg::OP_LDSP &&
    fSize != lsd_pkg::SZ_WORD24 && (fSize != lsd_pkg::SZ_HALF || !(s.sp[0] ^ fImm7[0])) |=>
    dRead && dAddr == $past(s.sp) + {17'h00000, $past(fImm7)})
    else $error("stack address wrong");
  chk_misalign: assert property (runOk && fSize == lsd_pkg::SZ_HALF &&
    ((opc == lsd_pkg::OP_STSP && !s.extValid && (s.sp[0] ^ fImm7[0])) ||
    ((opc == lsd_pkg::OP_LDRB || opc == lsd_pkg::OP_STRB) &&
    fMode != lsd_pkg::AM_PREDEC && srcVal[0])) |=> !dWrite && dRead &&
    dAddr == lsd_pkg::TABLE_BASE + 24'h000004 ##0 s.state == lsd_pkg::LSD_VEC)
    else $error("misaligned half not trapped");
  chk_vec_jump: assert property (s.state == lsd_pkg::LSD_VEC && dAck |=>
    iAddr == $past(dRdata[23:0]) && !dRead) else $error("vector branch wrong");

  cov_load_done: cover property (s.state == lsd_pkg::LSD_MEM && dAck && dRead);
  cov_store_done: cover property (s.state == lsd_pkg::LSD_MEM && dAck && dWrite);
  cov_ext_irq: cover property (s.state == lsd_pkg::LSD_RUN && intReq && !s.nmiPend);
  cov_cop_done: cover property (s.state == lsd_pkg::LSD_COP && copDone);
endmodule

// file: lsd_pkg.sv
package lsd_pkg;
  typedef enum logic [1:0] {
    LSD_RUN = 2'b00,
    LSD_MEM = 2'b01,
    LSD_VEC = 2'b11,
    LSD_COP = 2'b10
  } lsd_state_t;

  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_EXT = 4'h1;
  localparam logic [3:0] OP_MOVR = 4'h2;
  localparam logic [3:0] OP_MOVI = 4'h3;
  localparam logic [3:0] OP_LDRB = 4'h4;
  localparam logic [3:0] OP_STRB = 4'h5;
  localparam logic [3:0] OP_LDSP = 4'h6;
  localparam logic [3:0] OP_STSP = 4'h7;
  localparam logic [3:0] OP_LDAB = 4'h8;
  localparam logic [3:0] OP_STAB = 4'h9;
  localparam logic [3:0] OP_SWI = 4'hA;
  localparam logic [3:0] OP_COP = 4'hC;
  localparam logic [3:0] OP_IEN = 4'hE;

  localparam logic [1:0] SZ_SBYTE = 2'h0;
  localparam logic [1:0] SZ_UBYTE = 2'h1;
  localparam logic [1:0] SZ_HALF = 2'h2;
  localparam logic [1:0] SZ_WORD24 = 2'h3;

  localparam logic [1:0] AM_PLAIN = 2'h0;
  localparam logic [1:0] AM_POSTINC = 2'h1;
  localparam logic [1:0] AM_POSTDEC = 2'h2;
  localparam logic [1:0] AM_PREDEC = 2'h3;

  localparam logic [1:0] MI_SHORT_SIGNED_IMMEDIATE = 2'h0;
  localparam logic [1:0] MI_ZERO7 = 2'h1;
  localparam logic [1:0] MI_SETSP = 2'h2;
  localparam logic [1:0] MI_GETSP = 2'h3;

  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_MISALIGN = 6'h01;
  localparam logic [5:0] VEC_NMI = 6'h02;
  localparam logic [5:0] VEC_DEBUG = 6'h03;
  localparam logic [5:0] VEC_EXT0 = 6'h04;

  localparam logic [23:0] TABLE_BASE = 24'h000000;
  localparam logic [23:0] INSTR_BYTES = 24'h000002;
  localparam logic [23:0] STEP_BYTE = 24'h000001;
  localparam logic [23:0] STEP_HALF = 24'h000002;
  localparam int PSR_IE = 4;
  localparam logic [3:0] BE_ALL = 4'hF;

  typedef struct packed {
    lsd_state_t state;
    logic [23:0] iAddr;
    logic [7:0][23:0] gpr;
    logic [23:0] sp;
    logic [7:0] psr;
    logic [23:0] ext;
    logic extValid;
    logic nmiPend;
    logic [2:0] destReg;
    logic [1:0] memSize;
    logic [23:0] dAddr;
    logic [3:0] dBe;
    logic [31:0] dWdata;
    logic dRead;
    logic dWrite;
    logic copStart;
    logic [1:0] copOp;
    logic [15:0] copA;
    logic [15:0] copB;
  } lsd_core_s_t;
endpackage

// file: lsd_mem_model.sv
`timescale 1ns/100ps
module lsd_mem_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Answer latency chosen by the bench.
  input wire logic [3:0] ackDelay,
  // Instruction side.
  input wire logic [23:0] iAddr,
  output logic [15:0] iData,
  output logic iValid,
  // Data side.
  input wire logic [23:0] dAddr,
  input wire logic [3:0] dBe,
  input wire logic [31:0] dWdata,
  input wire logic dRead,
  input wire logic dWrite,
  output logic [31:0] dRdata,
  output logic dAck
);
  logic [15:0] imem [0:511];
  logic [7:0] dmem [0:1023];
  logic [24:0] accLog [$];
  logic [3:0] waitCnt;
  logic [9:0] base;

  assign iValid = 1'b1;
  assign iData = imem[iAddr[9:1]];
  assign base = {dAddr[9:2], 2'h0};

  // Outside an answer the read lines toggle so no stale word can pass for data.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dAck <= 1'b0;
      waitCnt <= 4'h0;
      dRdata <= 32'h5A5A5A5A;
      accLog.delete();
    end else begin
      dAck <= 1'b0;
      dRdata <= ~dRdata;
      if ((dRead || dWrite) && !dAck) begin
        if (waitCnt >= ackDelay) begin
          waitCnt <= 4'h0;
          dAck <= 1'b1;
          accLog.push_back({dWrite, dAddr});
          for (int n = 0; n < 4; n++) begin
            dRdata[8*n +: 8] <= dmem[base + n];
            if (dWrite && dBe[n]) begin
              dmem[base + n] <= dWdata[8*n +: 8];
            end
          end
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule

// file: cpu_load_store_decode_tb_top.sv
`timescale 1ns/100ps
module cpu_load_store_decode_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] ackDelay = 4'h0;
  logic [23:0] iAddr, dAddr;
  logic [15:0] iData;
  logic iValid, dRead, dWrite, dAck;
  logic [3:0] dBe;
  logic [31:0] dWdata, dRdata;
  logic [23:0] full;
  logic copStart;
  logic copDone = 1'b0;
  logic [1:0] copOp;
  logic [15:0] copA, copB;
  logic [31:0] copResult = 32'h00000000;
  logic [23:0] expAddr [$];
  logic [15:0] prog [$];
  int failCount = 0;
  int samplesChecked = 0;

  always #12.5 core_clk = ~core_clk;

  lsd_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .iAddr(iAddr), .iData(iData),
    .iValid(iValid), .dAddr(dAddr), .dBe(dBe), .dWdata(dWdata), .dRead(dRead),
    .dWrite(dWrite), .dRdata(dRdata), .dAck(dAck), .nmiReq(1'b0), .dbgReq(1'b0),
    .irq(32'h00000000), .copStart(copStart), .copOp(copOp), .copA(copA), .copB(copB),
    .copResult(copResult), .copDone(copDone));

  // Coprocessor stand-in: answers one cycle after the start pulse with a XOR of the operands.
  always @(posedge core_clk) begin
    copDone <= copStart;
    copResult <= {16'h0000, copA ^ copB};
  end

  lsd_mem_model i_mem (.core_clk(core_clk), .rst_n(rst_n), .ackDelay(ackDelay),
    .iAddr(iAddr), .iData(iData), .iValid(iValid), .dAddr(dAddr), .dBe(dBe),
    .dWdata(dWdata), .dRead(dRead), .dWrite(dWrite), .dRdata(dRdata), .dAck(dAck));

  function automatic logic [15:0] enc(input logic [3:0] op, input logic [1:0] sz,
      input logic [2:0] rd, input logic [6:0] low);
    return {op, sz, rd, low};
  endfunction

  function automatic logic [6:0] am(input logic [2:0] rb, input logic [1:0] mode);
    return {rb, mode, 2'h0};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reportAndStop();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Reset the core, load the program at 0x100 and wait for the data accesses.
  task automatic runProg(input logic [3:0] lat, input int entries);
    int k;
    @(posedge core_clk);
    rst_n <= 1'b0;
    ackDelay <= lat;
    for (k = 0; k < 512; k++) begin
      i_mem.imem[k] = 16'h0000;
    end
    foreach (prog[j]) begin
      i_mem.imem[128 + j] = prog[j];
    end
    for (k = 0; k < 8; k++) begin
      i_mem.dmem[k] = (k == 1 || k == 5) ? 8'h01 : 8'h00;
    end
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 600 && i_mem.accLog.size() < entries; k++) begin
      @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
    #1;
    if (i_mem.accLog.size() < entries) begin
      failCount++;
      $display("[ERR] access count expected %0d seen %0d", entries, i_mem.accLog.size());
      reportAndStop();
    end
  endtask

  task automatic chkWrites(input string name);
    foreach (expAddr[k]) begin
      chk("store address", i_mem.accLog[k + 1], {1'b1, expAddr[k]});
    end
    $display("Test %s finished", name);
  endtask

  task automatic testByteLoads();
    i_mem.dmem[64] = 8'h85;
    i_mem.dmem[85] = 8'hAA;
    prog = '{enc(4'h3, 2'h1, 3'h1, 7'h40), enc(4'h4, 2'h0, 3'h2, am(3'h1, 2'h0)),
      enc(4'h9, 2'h2, 3'h2, 7'h50), enc(4'h4, 2'h1, 3'h3, am(3'h1, 2'h0)),
      enc(4'h9, 2'h2, 3'h3, 7'h52), enc(4'h9, 2'h0, 3'h2, 7'h54)};
    runProg(4'h0, 6);
    chk("signed byte", {i_mem.dmem[81], i_mem.dmem[80]}, 32'h0000FF85);
    chk("unsigned byte", {i_mem.dmem[83], i_mem.dmem[82]}, 32'h00000085);
    chk("byte store", {i_mem.dmem[85], i_mem.dmem[84]}, 32'h0000AA85);
    $display("Test byte_loads finished");
  endtask

  task automatic testModes();
    prog = '{enc(4'h3, 2'h0, 3'h4, 7'h11), enc(4'h3, 2'h1, 3'h1, 7'h60),
      enc(4'h5, 2'h0, 3'h4, am(3'h1, 2'h1)), enc(4'h5, 2'h0, 3'h4, am(3'h1, 2'h0)),
      enc(4'h5, 2'h0, 3'h4, am(3'h1, 2'h2)), enc(4'h5, 2'h0, 3'h4, am(3'h1, 2'h3)),
      enc(4'h3, 2'h1, 3'h1, 7'h70), enc(4'h5, 2'h2, 3'h4, am(3'h1, 2'h1)),
      enc(4'h5, 2'h2, 3'h4, am(3'h1, 2'h0))};
    expAddr = '{24'h000060, 24'h000061, 24'h000061, 24'h00005F, 24'h000070, 24'h000072};
    runProg(4'h2, 7);
    chk("half store", {i_mem.dmem[115], i_mem.dmem[114]}, 32'h00000011);
    chkWrites("address_modes");
  endtask

  task automatic testStack();
    prog = '{enc(4'h3, 2'h1, 3'h5, 7'h30), enc(4'h3, 2'h2, 3'h5, 7'h00),
      enc(4'h3, 2'h0, 3'h6, 7'h7E), enc(4'h7, 2'h2, 3'h6, 7'h12),
      enc(4'h6, 2'h2, 3'h7, 7'h12), enc(4'h9, 2'h0, 3'h7, 7'h58),
      16'h1002, enc(4'h3, 2'h1, 3'h3, 7'h00), enc(4'h5, 2'h0, 3'h6, am(3'h3, 2'h0))};
    runProg(4'h1, 5);
    chk("stack address", i_mem.accLog[1], {1'b1, 24'h000042});
    chk("signed imm", {i_mem.dmem[67], i_mem.dmem[66]}, 32'h0000FFFE);
    chk("stack load", i_mem.dmem[88], 32'h000000FE);
    chk("prefixed base", i_mem.accLog[4], {1'b1, 24'h000100});
    $display("Test stack_forms finished");
  endtask

  task automatic testMoves();
    full = {17'h0A123, 7'h05};
    prog = '{16'h100A, 16'h1123, enc(4'h3, 2'h1, 3'h1, 7'h05),
      enc(4'h2, 2'h3, 3'h2, am(3'h1, 2'h0)), enc(4'h2, 2'h2, 3'h3, am(3'h1, 2'h0)),
      enc(4'h2, 2'h0, 3'h4, am(3'h1, 2'h0)), enc(4'h2, 2'h1, 3'h5, am(3'h1, 2'h0)),
      enc(4'h5, 2'h0, 3'h6, am(3'h2, 2'h0)), enc(4'h5, 2'h0, 3'h6, am(3'h3, 2'h0)),
      enc(4'h5, 2'h0, 3'h6, am(3'h4, 2'h0)), enc(4'h5, 2'h0, 3'h6, am(3'h5, 2'h0))};
    expAddr = '{full, {8'h00, full[15:0]}, {{16{full[7]}}, full[7:0]}, {16'h0000, full[7:0]}};
    runProg(4'h0, 5);
    chkWrites("register_moves");
  endtask

  task automatic testMisalign();
    prog = '{enc(4'h3, 2'h1, 3'h1, 7'h41), enc(4'h4, 2'h2, 3'h2, am(3'h1, 2'h1))};
    runProg(4'h3, 2);
    chk("misalign vector", i_mem.accLog[1], {1'b0, lsd_pkg::TABLE_BASE + {16'h0000,
      lsd_pkg::VEC_MISALIGN, 2'h0}});
    $display("Test misalign finished");
  endtask

  task automatic testCoproc();
    prog = '{enc(4'h3, 2'h1, 3'h1, 7'h12), enc(4'h3, 2'h1, 3'h2, 7'h34),
      enc(4'hC, 2'h2, 3'h1, am(3'h2, 2'h0)), enc(4'h9, 2'h2, 3'h1, 7'h5C)};
    runProg(4'h1, 2);
    chk("cop result", {i_mem.dmem[93], i_mem.dmem[92]}, 32'h00000026);
    chk("cop operand a", copA, 32'h00000012);
    chk("cop operand b", copB, 32'h00000034);
    chk("cop op", copOp, 32'h00000002);
    $display("Test coprocessor finished");
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    testCoproc();
    testByteLoads();
    testModes();
    testStack();
    testMoves();
    testMisalign();
    reportAndStop();
  end
endmodule
